// ---- vsf_defines.vh ----
// vsf_defines.vh: offsets, fields and constants of the front end.
// assumes: included by the design file, byte addresses on 8 bits.
`ifndef VSF_DEFINES_VH
`define VSF_DEFINES_VH
// --------------------
// register map (byte addresses)
// --------------------
`define VSF_OFF_CTRL 8'h00
`define VSF_OFF_STATUS 8'h04
`define VSF_OFF_THR_SET 8'h08
`define VSF_OFF_THR_ACT 8'h0C
`define VSF_OFF_ENERGY_LO 8'h10
`define VSF_OFF_ENERGY_HI 8'h14
`define VSF_OFF_DIST 8'h18
`define VSF_OFF_ACF 8'h20
`define VSF_ACF_LAST 6'd8
// --------------------
// field positions
// --------------------
`define VSF_CTRL_START 0
`define VSF_CTRL_PITCH 1
`define VSF_CTRL_TONE 2
`define VSF_ST_BUSY 0
`define VSF_ST_SPEECH 1
`define VSF_ST_STAT 2
`define VSF_ST_DONE 3
// --------------------
// algorithm constants and reset values
// --------------------
`define VSF_FRAME_MS 20
`define VSF_AVG_FRAMES 4
`define VSF_ORDER 4'd8
`define VSF_QBITS 12
`define VSF_A0_INT (-1)
`define VSF_STAT_NUM 40'd5
`define VSF_STAT_DEN 40'd100
`define VSF_THR_RST 32'h000F4240
`define VSF_RVAD0 6
`define VSF_RVAD1 (-4)
`define VSF_RVAD2 1
`define VSF_DM_RST 32'h00000000
`define VSF_RESP_OKAY 2'b00
`define VSF_RESP_SLVERR 2'b10
`endif

// ---- vsf_front.v ----
// vsf_front.v: per-frame spectral front end of a voice activity detector
// with an AXI4-Lite register slave.
// assumes: software loads the nine frame correlations, then starts a frame
// once per frame period; all inputs but reset_n synchronous to core_clk.
//
// Our own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "vsf_defines.vh"

// Operation
// - one evaluation and decision per frame
// - energy from active coefficients and correlations
// - recent sum spans four frames
// - delayed sum is recent sum four frames back
// - eight predictors from Toeplitz solve, a0 = -1
// - predictors use delayed sum only
// - candidate correlation of predictor coefficients
// - distortion from candidate and recent sums
// - stationary when distortion change below 0.05
// - adapt filter and threshold only without speech
// - adapt needs stationary, no pitch, no tone
// - speech when energy exceeds threshold
module vsf_front #(
    parameter COEF_W = 16
) (
    input wire core_clk,
    input wire reset_n,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    output wire speech_flag,
    output wire stat_flag
);
    localparam SUM_W = 34;
    localparam ACC_W = 80;
    localparam DIV_W = 72;
    localparam Q = `VSF_QBITS;
    localparam [3:0] S_IDLE = 4'd0, S_EN = 4'd1, S_AVG = 4'd2,
        S_LINIT = 4'd3, S_LACC = 4'd4, S_LDIV = 4'd5, S_LUPD = 4'd6,
        S_RAV = 4'd7, S_DACC = 4'd8, S_DDIV = 4'd9, S_DEC = 4'd10;
    localparam [3:0] LAST = 4'd8;

    reg signed [31:0] acf_q [0:8];
    reg signed [31:0] hist_q [0:35];
    reg signed [SUM_W-1:0] shist_q [0:35];
    reg signed [SUM_W-1:0] recent_autocorr_sum [0:8];
    reg signed [SUM_W-1:0] delayed_autocorr_sum [0:8];
    reg signed [COEF_W-1:0] predictor_coeffs [0:8];
    reg signed [31:0] candidate_filter_autocorr [0:8];
    reg signed [31:0] rvad_q [0:8];
    reg [1:0] ptr_q;
    reg [3:0] st_q, idx_q, ord_q;
    reg [6:0] dcnt_q;
    reg signed [ACC_W-1:0] acc_q;
    reg signed [47:0] err_q;
    reg [DIV_W-1:0] quo_q;
    reg [DIV_W:0] rem_q;
    reg neg_q;
    reg signed [63:0] energy_q;
    reg signed [31:0] spectral_distortion, last_dm_q;
    reg [31:0] thr_set_q, thr_act_q;
    reg pitch_q, tone_q, speech_q, stat_q, done_q, start_q;
    reg awready_q, wready_q, aw_got_q, w_got_q, bvalid_q, arready_q;
    reg rvalid_q;
    reg [7:0] awaddr_q;
    reg [31:0] wdata_q, rdata_q;
    reg [3:0] wstrb_q;
    reg [1:0] bresp_q, rresp_q;
    // one loop index per process so no two processes share a variable
    integer n, j, k, m;

    // --------------------
    // datapath helpers
    // --------------------
    wire busy = (st_q != S_IDLE);
    wire [5:0] hidx = ({4'b0, ptr_q} * 6'd9) + {2'b0, idx_q};
    wire signed [SUM_W-1:0] new_rsum = recent_autocorr_sum[idx_q]
        - hist_q[hidx] + acf_q[idx_q];
    reg signed [31:0] mul_a;
    reg signed [SUM_W-1:0] mul_b;
    // one multiplier shared by energy and distortion sums
    always @* begin
        mul_a = candidate_filter_autocorr[idx_q];
        mul_b = recent_autocorr_sum[idx_q];
        if (st_q == S_EN) begin
            mul_a = rvad_q[idx_q];
            mul_b = acf_q[idx_q];
        end
    end
    wire signed [65:0] mprod = mul_a * mul_b;
    wire signed [ACC_W-1:0] mterm = (idx_q == 4'd0) ? mprod : mprod <<< 1;
    // recursion reads the delayed sum only
    wire signed [49:0] lprod = predictor_coeffs[idx_q]
        * delayed_autocorr_sum[ord_q - idx_q];

    // shared restoring divider, magnitude only
    wire [ACC_W-1:0] acc_abs = acc_q[ACC_W-1] ? -acc_q : acc_q;
    wire [DIV_W-1:0] dvs = (st_q == S_LDIV)
        ? {{(DIV_W-48){1'b0}}, err_q}
        : {{(DIV_W-SUM_W){1'b0}}, recent_autocorr_sum[0]};
    wire [DIV_W:0] rsh = {rem_q[DIV_W-1:0], quo_q[DIV_W-1]};
    wire dge = rsh >= {1'b0, dvs};

    // reflection term limited below unity to keep the filter stable
    wire [COEF_W-1:0] kmag = (quo_q > ((1 << Q) - 1)) ? ((1 << Q) - 1)
        : quo_q[COEF_W-1:0];
    wire signed [COEF_W-1:0] k_w = neg_q ? -kmag : kmag;
    wire signed [31:0] kk = k_w * k_w;
    wire signed [79:0] ekk = err_q * kk;
    wire signed [47:0] err_n = err_q - ekk[71:24];

    // order-recursive solution, a0 held at -1
    reg signed [COEF_W-1:0] pc_n [0:8];
    reg signed [31:0] up;
    always @* begin
        up = 32'sh0;
        for (j = 0; j <= 8; j = j + 1) begin
            pc_n[j] = predictor_coeffs[j];
            if (j != 0 && j < ord_q) begin
                up = k_w * predictor_coeffs[ord_q - j];
                pc_n[j] = predictor_coeffs[j] - up[Q+COEF_W-1:Q];
            end else if (j == ord_q) begin
                pc_n[j] = k_w;
            end
        end
    end

    // candidate correlation of the coefficient vector
    reg signed [35:0] rav_s;
    reg signed [COEF_W-1:0] ca, cb;
    always @* begin
        rav_s = 36'sh0;
        ca = 0;
        cb = 0;
        for (k = 0; k <= 8; k = k + 1) begin
            if (k + idx_q <= 8) begin
                ca = (k == 0) ? `VSF_A0_INT * (1 << Q) : predictor_coeffs[k];
                cb = (k + idx_q == 0) ? `VSF_A0_INT * (1 << Q)
                    : predictor_coeffs[k + idx_q];
                rav_s = rav_s + ca * cb;
            end
        end
    end

    // distortion, its change and the decision terms
    wire [31:0] dmag = (|quo_q[DIV_W-1:31]) ? 32'h7FFFFFFF
        : {1'b0, quo_q[30:0]};
    wire signed [31:0] dm_w = (recent_autocorr_sum[0] > 0)
        ? (neg_q ? -dmag : dmag) : `VSF_DM_RST;
    wire signed [32:0] dd = dm_w - last_dm_q;
    wire [39:0] dabs = dd[32] ? -dd : dd;
    // compare |change| * den against num in Q format
    wire stat_w = (dabs * `VSF_STAT_DEN) < (`VSF_STAT_NUM << Q);
    wire speech_w = energy_q > $signed({32'h00000000, thr_act_q});
    // adapt only when stationary and free of pitch and tone
    wire adapt_w = ~speech_w & stat_w & ~pitch_q & ~tone_q;

    // --------------------
    // frame sequencer
    // --------------------
    // energy, averaging, predictor, candidate, comparison
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= S_IDLE;
            idx_q <= 4'd0;
            ord_q <= 4'd1;
            ptr_q <= 2'd0;
            dcnt_q <= 7'd0;
            acc_q <= 0;
            err_q <= 0;
            quo_q <= 0;
            rem_q <= 0;
            neg_q <= 1'b0;
            energy_q <= 0;
            spectral_distortion <= `VSF_DM_RST;
            last_dm_q <= `VSF_DM_RST;
            thr_act_q <= `VSF_THR_RST;
            speech_q <= 1'b0;
            stat_q <= 1'b0;
            done_q <= 1'b0;
            // histories and sums start from zero
            for (n = 0; n < 36; n = n + 1) begin
                hist_q[n] <= 0;
                shist_q[n] <= 0;
            end
            for (n = 0; n <= 8; n = n + 1) begin
                recent_autocorr_sum[n] <= 0;
                delayed_autocorr_sum[n] <= 0;
                predictor_coeffs[n] <= 0;
                candidate_filter_autocorr[n] <= 0;
                rvad_q[n] <= 0;
            end
            rvad_q[0] <= `VSF_RVAD0 * (1 << Q);
            rvad_q[1] <= `VSF_RVAD1 * (1 << Q);
            rvad_q[2] <= `VSF_RVAD2 * (1 << Q);
        end else begin
            case (st_q)
            S_IDLE: begin
                if (start_q) begin
                    st_q <= S_EN;
                    idx_q <= 4'd0;
                    acc_q <= 0;
                    done_q <= 1'b0;
                end
            end
            S_EN: begin
                acc_q <= acc_q + mterm;
                idx_q <= (idx_q == LAST) ? 4'd0 : idx_q + 4'd1;
                if (idx_q == LAST)
                    st_q <= S_AVG;
            end
            S_AVG: begin
                if (idx_q == 4'd0)
                    energy_q <= acc_q[Q+63:Q];
                recent_autocorr_sum[idx_q] <= new_rsum;
                hist_q[hidx] <= acf_q[idx_q];
                delayed_autocorr_sum[idx_q] <= shist_q[hidx];
                shist_q[hidx] <= new_rsum;
                idx_q <= (idx_q == LAST) ? 4'd0 : idx_q + 4'd1;
                if (idx_q == LAST) begin
                    ptr_q <= ptr_q + 2'd1;
                    st_q <= S_LINIT;
                end
            end
            S_LINIT: begin
                for (n = 0; n <= 8; n = n + 1)
                    predictor_coeffs[n] <= 0;
                err_q <= delayed_autocorr_sum[0];
                ord_q <= 4'd1;
                st_q <= (delayed_autocorr_sum[0] > 0) ? S_LACC : S_RAV;
            end
            S_LACC: begin
                if (idx_q == 4'd0)
                    acc_q <= delayed_autocorr_sum[ord_q] <<< Q;
                else
                    acc_q <= acc_q - lprod;
                idx_q <= idx_q + 4'd1;
                dcnt_q <= 7'd0;
                if (idx_q == ord_q - 4'd1)
                    st_q <= S_LDIV;
            end
            S_LDIV, S_DDIV: begin
                dcnt_q <= dcnt_q + 7'd1;
                if (dcnt_q == 7'd0) begin
                    rem_q <= 0;
                    quo_q <= acc_abs[DIV_W-1:0];
                    neg_q <= acc_q[ACC_W-1];
                end else begin
                    quo_q <= {quo_q[DIV_W-2:0], dge};
                    rem_q <= dge ? rsh - {1'b0, dvs} : rsh;
                end
                if (dcnt_q == DIV_W) begin
                    st_q <= (st_q == S_LDIV) ? S_LUPD : S_DEC;
                    idx_q <= 4'd0;
                end
            end
            S_LUPD: begin
                for (n = 1; n <= 8; n = n + 1)
                    predictor_coeffs[n] <= pc_n[n];
                err_q <= err_n;
                ord_q <= ord_q + 4'd1;
                st_q <= (err_n <= 0 || ord_q == `VSF_ORDER) ? S_RAV : S_LACC;
            end
            S_RAV: begin
                candidate_filter_autocorr[idx_q] <= rav_s[Q+31:Q];
                idx_q <= (idx_q == LAST) ? 4'd0 : idx_q + 4'd1;
                acc_q <= 0;
                if (idx_q == LAST)
                    st_q <= S_DACC;
            end
            S_DACC: begin
                acc_q <= acc_q + mterm;
                idx_q <= idx_q + 4'd1;
                dcnt_q <= 7'd0;
                if (idx_q == LAST)
                    st_q <= S_DDIV;
            end
            default: begin
                spectral_distortion <= dm_w;
                last_dm_q <= dm_w;
                stat_q <= stat_w;
                speech_q <= speech_w;
                if (adapt_w) begin
                    thr_act_q <= thr_set_q;
                    for (n = 0; n <= 8; n = n + 1)
                        rvad_q[n] <= candidate_filter_autocorr[n];
                end
                done_q <= 1'b1;
                st_q <= S_IDLE;
            end
            endcase
        end
    end

    // --------------------
    // AXI4-Lite slave
    // --------------------
    function [31:0] wmerge(input [31:0] o, input [31:0] d, input [3:0] s);
        integer b;
        begin
            wmerge = o;
            for (b = 0; b < 4; b = b + 1)
                if (s[b])
                    wmerge[b*8 +: 8] = d[b*8 +: 8];
        end
    endfunction
    wire [7:0] wrel = awaddr_q - `VSF_OFF_ACF;
    wire [7:0] rrel = s_axi_araddr - `VSF_OFF_ACF;
    wire w_acf = (awaddr_q >= `VSF_OFF_ACF) && (wrel[7:2] <= `VSF_ACF_LAST);
    wire r_acf = (s_axi_araddr >= `VSF_OFF_ACF)
        && (rrel[7:2] <= `VSF_ACF_LAST);
    reg [31:0] rd_d;
    reg [1:0] rr_d;
    // read decode, unmapped answers slave error
    always @* begin
        rd_d = 32'h00000000;
        rr_d = `VSF_RESP_OKAY;
        if (s_axi_araddr[1:0] != 2'b00)
            rr_d = `VSF_RESP_SLVERR;
        else if (s_axi_araddr == `VSF_OFF_CTRL)
            rd_d = {29'h0, tone_q, pitch_q, 1'b0};
        else if (s_axi_araddr == `VSF_OFF_STATUS)
            rd_d = {28'h0, done_q, stat_q, speech_q, busy};
        else if (s_axi_araddr == `VSF_OFF_THR_SET)
            rd_d = thr_set_q;
        else if (s_axi_araddr == `VSF_OFF_THR_ACT)
            rd_d = thr_act_q;
        else if (s_axi_araddr == `VSF_OFF_ENERGY_LO)
            rd_d = energy_q[31:0];
        else if (s_axi_araddr == `VSF_OFF_ENERGY_HI)
            rd_d = energy_q[63:32];
        else if (s_axi_araddr == `VSF_OFF_DIST)
            rd_d = spectral_distortion;
        else if (r_acf)
            rd_d = acf_q[rrel[5:2]];
        else
            rr_d = `VSF_RESP_SLVERR;
    end

    // channels; writes land once address and data are both held
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            {awready_q, wready_q, aw_got_q, w_got_q, bvalid_q} <= 5'h00;
            {arready_q, rvalid_q, start_q, pitch_q, tone_q} <= 5'h00;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            bresp_q <= `VSF_RESP_OKAY;
            rresp_q <= `VSF_RESP_OKAY;
            rdata_q <= 32'h00000000;
            thr_set_q <= `VSF_THR_RST;
            for (m = 0; m <= 8; m = m + 1)
                acf_q[m] <= 0;
        end else begin
            start_q <= 1'b0;
            if (awready_q && s_axi_awvalid) begin
                aw_got_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
                awready_q <= 1'b0;
            end else if (!aw_got_q && !bvalid_q) begin
                awready_q <= 1'b1;
            end
            if (wready_q && s_axi_wvalid) begin
                w_got_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
                wready_q <= 1'b0;
            end else if (!w_got_q && !bvalid_q) begin
                wready_q <= 1'b1;
            end
            if (aw_got_q && w_got_q && !bvalid_q) begin
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= `VSF_RESP_OKAY;
                if (awaddr_q[1:0] != 2'b00) begin
                    bresp_q <= `VSF_RESP_SLVERR;
                end else if (awaddr_q == `VSF_OFF_CTRL) begin
                    if (wstrb_q[0]) begin
                        // start is dropped while a frame is in flight
                        start_q <= wdata_q[`VSF_CTRL_START] & ~busy;
                        pitch_q <= wdata_q[`VSF_CTRL_PITCH];
                        tone_q <= wdata_q[`VSF_CTRL_TONE];
                    end
                end else if (awaddr_q == `VSF_OFF_THR_SET) begin
                    thr_set_q <= wmerge(thr_set_q, wdata_q, wstrb_q);
                end else if (w_acf) begin
                    // correlations frozen while the frame runs
                    if (!busy)
                        acf_q[wrel[5:2]] <= wmerge(acf_q[wrel[5:2]],
                            wdata_q, wstrb_q);
                end else if (!(awaddr_q == `VSF_OFF_STATUS
                    || (awaddr_q >= `VSF_OFF_THR_ACT
                    && awaddr_q <= `VSF_OFF_DIST))) begin
                    bresp_q <= `VSF_RESP_SLVERR;
                end
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
            if (arready_q && s_axi_arvalid) begin
                arready_q <= 1'b0;
                rvalid_q <= 1'b1;
                rdata_q <= rd_d;
                rresp_q <= rr_d;
            end else if (rvalid_q && s_axi_rready) begin
                rvalid_q <= 1'b0;
                arready_q <= 1'b1;
            end else if (!rvalid_q) begin
                arready_q <= 1'b1;
            end
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign speech_flag = speech_q;
    assign stat_flag = stat_q;
endmodule // vsf_front

// ---- vsf_enc_model.sv ----
// vsf_enc_model.sv: speech encoder stand-in holding per-frame correlations.
// assumes: the bench picks a set and an index and copies the word over.
`timescale 1ns/1ps
module vsf_enc_model (
    input wire logic enc_sel,
    input wire logic [3:0] enc_idx,
    output logic [31:0] enc_val
);
    // small correlations
    // values stay well inside what 16-bit samples can give
    always_comb begin
        if (enc_idx > 4'h8) begin
            enc_val = 32'h00000000;
        end else if (enc_sel) begin
            enc_val = (enc_idx == 4'h0) ? 32'h00001388 : 32'h00000000;
        end else begin
            case (enc_idx)
                4'h0: enc_val = 32'h000003E8;
                4'h1: enc_val = 32'h00000064;
                4'h2: enc_val = 32'h0000000A;
                default: enc_val = 32'h00000005;
            endcase
        end
    end
endmodule // vsf_enc_model

// ---- vsf_front_props.sv ----
// vsf_front_props.sv: assertions on the bus and flag ports.
// assumes: bound to vsf_front, one clock, reset_n async active low.
`timescale 1ns/1ps
module vsf_front_props (
    input wire core_clk,
    input wire reset_n,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire speech_flag,
    input wire stat_flag
);
    // cycles since last write response, saturating; a frame needs a start
    logic [9:0] since_b_q;
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            since_b_q <= 10'h3FF;
        end else if (s_axi_bvalid && s_axi_bready) begin
            since_b_q <= 10'h000;
        end else if (since_b_q != 10'h3FF) begin
            since_b_q <= since_b_q + 10'h001;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    sequence s_w_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_r_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_reopen;
        !s_axi_bvalid ##1 (s_axi_awready && s_axi_wready);
    endsequence
    property p_b_next;
        s_w_taken |-> ##2 s_axi_bvalid;
    endproperty
    a_b_next: assert property (p_b_next) else $error("late write resp");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
    property p_reopen;
        s_axi_bvalid && s_axi_bready |=> s_reopen;
    endproperty
    a_reopen: assert property (p_reopen) else $error("write not reopened");
    property p_w_bad;
        s_w_taken and s_axi_awaddr[1:0] != 2'h0 |-> ##2 s_axi_bresp == 2'h2;
    endproperty
    a_w_bad: assert property (p_w_bad) else $error("unaligned write ok");
    property p_r_next;
        s_r_taken |=> s_axi_rvalid && !s_axi_arready;
    endproperty
    a_r_next: assert property (p_r_next) else $error("late read data");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data moved");
    property p_r_bad;
        s_r_taken and s_axi_araddr[1:0] != 2'h0
            |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
    endproperty
    a_r_bad: assert property (p_r_bad) else $error("unaligned read ok");
    property p_flags_need_start;
        since_b_q == 10'h3FF |-> $stable(speech_flag) && $stable(stat_flag);
    endproperty
    a_flags_need_start: assert property (p_flags_need_start)
        else $error("flags moved with no frame");
endmodule // vsf_front_props
bind vsf_front vsf_front_props i_props (.core_clk(core_clk),
    .reset_n(reset_n), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .speech_flag(speech_flag), .stat_flag(stat_flag));

// ---- vsf_front_bench.sv ----
// vsf_front_bench.sv: self-checking bench of the spectral front end.
// assumes: vsf_front, vsf_enc_model and the bound checker are compiled.
`timescale 1ns/1ps
`include "vsf_defines.vh"
module vsf_front_bench;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, enc_val;
    logic [3:0] s_axi_wstrb = 4'hF, enc_idx = 4'h0;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, enc_sel = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, speech_flag, stat_flag;
    int n_fail = 0;
    int tests_run = 0;
    vsf_front i_dut (.core_clk(core_clk), .reset_n(reset_n),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .speech_flag(speech_flag),
        .stat_flag(stat_flag));
    vsf_enc_model i_enc (.enc_sel(enc_sel), .enc_idx(enc_idx),
        .enc_val(enc_val));
    // 250 MHz core clock
    always #2 core_clk = ~core_clk;
    // --------------------
    // compare and bus tasks
    // --------------------
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: word %h not %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_word({31'h0, got}, {31'h0, exp});
    endtask
    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        chk_word({30'h0, got}, {30'h0, exp});
    endtask
    // write: address and data offered together, each dropped when taken
    task automatic axw(input logic [7:0] a, input logic [31:0] d,
                       input logic [1:0] er);
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!(s_axi_bvalid && s_axi_bready));
        s_axi_bready <= 1'b0;
        chk_resp(s_axi_bresp, er);
    endtask
    // read: rready held until the data edge
    task automatic axr(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!(s_axi_rvalid && s_axi_rready));
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        axr(a, d);
        chk_word(d, e);
    endtask
    // --------------------
    // scenarios
    // --------------------
    // ld: reload correlations; poke: write ACF0 while the frame is busy
    task automatic run_frame(input logic ld, sel, poke,
        input logic [31:0] ctrl, e_en, input logic e_sp, e_st, c_st);
        logic [31:0] st;
        int n;
        for (int i = 0; i < 9 && ld; i++) begin
            enc_sel = sel;
            enc_idx = 4'(i);
            #1;
            axw(8'(`VSF_OFF_ACF + 4 * i), enc_val, `VSF_RESP_OKAY);
        end
        axw(`VSF_OFF_CTRL, ctrl, `VSF_RESP_OKAY);
        if (poke) axw(`VSF_OFF_ACF, 32'h00007777, `VSF_RESP_OKAY);
        n = 0;
        do begin
            axr(`VSF_OFF_STATUS, st);
            n++;
        end while (st[3] !== 1'b1 && n < 400);
        chk_bit(st[3], 1'b1);
        chk_bit(speech_flag, e_sp);
        rd_chk(`VSF_OFF_ENERGY_LO, e_en);
        rd_chk(`VSF_OFF_ENERGY_HI, 32'h0);
        if (c_st) chk_bit(stat_flag, e_st);
    endtask
    task automatic t_reset_vals;
        chk_bit(speech_flag, 1'b0);
        rd_chk(`VSF_OFF_THR_SET, `VSF_THR_RST);
        rd_chk(`VSF_OFF_THR_ACT, `VSF_THR_RST);
        rd_chk(`VSF_OFF_DIST, 32'h0);
        rd_chk(`VSF_OFF_STATUS, 32'h0);
    endtask
    task automatic t_refused;
        logic [31:0] d;
        axw(8'h02, 32'h1, `VSF_RESP_SLVERR);
        axw(8'h44, 32'h1, `VSF_RESP_SLVERR);
        axr(8'h1C, d);
        chk_word(d, 32'h0);
        axw(`VSF_OFF_STATUS, 32'hF, `VSF_RESP_OKAY);
        rd_chk(`VSF_OFF_STATUS, 32'h0);
    endtask
    // frame 1 from reset coefficients 6,-4,1: energy 6000-800+20
    task automatic t_frames;
        run_frame(1, 0, 1, 32'h1, 32'h1464, 0, 0, 1);
        rd_chk(`VSF_OFF_DIST, 32'h00001000);
        axw(`VSF_OFF_THR_SET, 32'h00000FA0, `VSF_RESP_OKAY);
        run_frame(0, 0, 0, 32'h3, 32'h1464, 0, 1, 1);
        rd_chk(`VSF_OFF_THR_ACT, `VSF_THR_RST);
        run_frame(0, 0, 0, 32'h5, 32'h1464, 0, 1, 1);
        rd_chk(`VSF_OFF_THR_ACT, `VSF_THR_RST);
        run_frame(0, 0, 0, 32'h1, 32'h1464, 0, 1, 1);
        rd_chk(`VSF_OFF_THR_ACT, 32'h00000FA0);
        axw(`VSF_OFF_THR_SET, 32'h9, `VSF_RESP_OKAY);
        run_frame(1, 1, 0, 32'h1, 32'h1388, 1, 0, 0);
        rd_chk(`VSF_OFF_THR_ACT, 32'h00000FA0);
    endtask
    // --------------------
    // verdict, watchdog and main sequence
    // --------------------
    task automatic close_out;
        $display("checks %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // five frames of under 1000 cycles each fit well inside this span
    initial begin
        #240000;
        n_fail++;
        close_out;
    end
    initial begin
        repeat (6) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        t_reset_vals;
        t_refused;
        t_frames;
        close_out;
    end
endmodule // vsf_front_bench
